//--- include/umsab_pkg.sv
// Package for the modem status, scratch and auto-baud register slice
package umsab_pkg;
   localparam logic [11:0] MLS_ADDR = 12'h018;
   localparam logic [11:0] SCR_ADDR = 12'h01C;
   localparam logic [11:0] ABC_ADDR = 12'h020;
   localparam int MLS_DCD_B = 7;
   localparam int MLS_RI_B = 6;
   localparam int MLS_DSR_B = 5;
   localparam int MLS_CTS_B = 4;
   localparam int ABC_TOC_B = 9;
   localparam int ABC_EOC_B = 8;
   localparam int ABC_RARM_B = 2;
   localparam int ABC_MODE_B = 1;
   localparam int ABC_START_B = 0;
   localparam int LB_DCD_B = 3;
   localparam int LB_RI_B = 2;
   localparam int LB_DSR_B = 0;
   localparam int LB_CTS_B = 1;
   localparam logic [3:0] MODEM_LINES_RST = 4'h6;
   localparam logic [7:0] SCR_RST = 8'h00;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   // Modem lines as seen by software: dcd, ri, dsr, cts (active high)
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } umsab_lines_t;
   // Auto-baud engine status strobes
   typedef struct packed {
      logic done;
      logic timeout;
   } umsab_ab_evt_t;
endpackage

//--- rtl/umsab_edge.sv
// Change detector for one modem line with sticky change flag
`timescale 1ns/100ps
`default_nettype none
module umsab_edge
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic level,
   input wire logic rst_level,
   input wire logic rise_only,
   input wire logic clr,
   output logic flag
);
   logic prev_q;
   logic hit;
   logic lvl_x;
   // Level relative to its reset value, so no false edge follows reset
   assign lvl_x = level ^ rst_level;
   assign hit = rise_only ? (lvl_x & ~prev_q) : (lvl_x ^ prev_q);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= 1'b0;
      else
         prev_q <= lvl_x;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flag <= 1'b0;
      else if (hit)
         flag <= 1'b1;
      else if (clr)
         flag <= 1'b0;
   end
endmodule
`default_nettype wire

//--- rtl/umsab_regs.sv
// Modem status, scratch and auto-baud control registers behind APB
// How it works
// - A change of carrier, set-ready or clear-to-send state raises the modem interrupt.
// - Ring state falling high-to-low raises the interrupt; rising does not.
// - Status bit 7 is inverted carrier input, or control bit 3 in loopback.
// - Bit 6 is inverted ring input, resets to 1, loopback uses control bit 2.
// - Bit 5 is inverted set-ready input, resets to 1, loopback control bit 0.
// - Bit 4 is inverted clear-to-send input, resets 0, loopback control bit 1.
// - Bit 3 sets on any carrier change, clears on status read.
// - Bit 2 sets on ring input rising only, clears on status read.
// - Bit 1 sets on any set-ready change, clears on status read.
// - Bit 0 sets on any clear-to-send change, clears on status read.
// - Status register is read-only; upper bits read zero; writes ignored.
// - Scratch byte is freely read and written, resets to zero.
// - Scratch accesses raise no interrupt or status.
// - Writing 1 to bit 9 clears the timeout flag; bit reads 0.
// - Writing 1 to bit 8 clears the done flag; bit reads 0.
// - With bit 2 set, a timed out measurement restarts at next falling receive edge.
// - Bit 1 selects measurement mode 0 or 1, resets 0.
// - Software sets bit 0 to start; it stays 1 until measurement completes or times out with bit 2 clear.
// - Auto-baud control register reads all zeros after reset.
`timescale 1ns/100ps
`default_nettype none
module umsab_regs
   import umsab_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Modem handshake inputs, active low as on the pins, and receive line
   input wire logic DCD_N,
   input wire logic RI_N,
   input wire logic DSR_N,
   input wire logic CTS_N,
   input wire logic RXD,
   // From the rest of the port
   input wire logic LOOPBACK,
   input wire logic [3:0] MODEM_CTRL,
   input wire logic MS_INT_EN,
   input wire umsab_pkg::umsab_ab_evt_t AB_EVT,
   // To the rest of the port
   output logic MS_INT,
   output logic AB_START,
   output logic AB_MODE,
   output logic AB_RESTART,
   output logic AB_DONE_FLAG,
   output logic AB_TIMEOUT_FLAG
);
   import umsab_pkg::*;

   logic setup_ph, wr_en, rd_en;
   logic hit_mls, hit_scr, hit_abc;
   umsab_lines_t lines_d, lines_q;
   logic [3:0] chg;
   logic [7:0] scr_q;
   logic rearm_q, mode_q, start_q;
   logic timed_out_q, rxd_q;
   logic [31:0] rdata_d;
   logic mls_rd;

   // Every access completes with one wait-free access phase
   assign setup_ph = PSEL & ~PENABLE;
   assign wr_en = PSEL & PENABLE & PWRITE;
   assign rd_en = PSEL & PENABLE & ~PWRITE;
   assign hit_mls = (PADDR == MLS_ADDR);
   assign hit_scr = (PADDR == SCR_ADDR);
   assign hit_abc = (PADDR == ABC_ADDR);
   assign mls_rd = rd_en & hit_mls;

   // Line state selection
   always_comb
   begin
      if (LOOPBACK)
      begin
         lines_d.dcd = MODEM_CTRL[LB_DCD_B];
         lines_d.ri = MODEM_CTRL[LB_RI_B];
         lines_d.dsr = MODEM_CTRL[LB_DSR_B];
         lines_d.cts = MODEM_CTRL[LB_CTS_B];
      end
      else
      begin
         lines_d.dcd = ~DCD_N;
         lines_d.ri = ~RI_N;
         lines_d.dsr = ~DSR_N;
         lines_d.cts = ~CTS_N;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         lines_q <= MODEM_LINES_RST;
      else
         lines_q <= lines_d;
   end

   // Change flags; set wins, and a read clears only flags it returned
   umsab_edge u_dcd (.clk(MCLK), .rst_n(RST_N), .level(lines_q.dcd), .rst_level(1'b0),
      .rise_only(1'b0), .clr(mls_rd & PRDATA[3]), .flag(chg[3]));
   umsab_edge u_ri (.clk(MCLK), .rst_n(RST_N), .level(~lines_q.ri), .rst_level(1'b0),
      .rise_only(1'b1), .clr(mls_rd & PRDATA[2]), .flag(chg[2]));
   umsab_edge u_dsr (.clk(MCLK), .rst_n(RST_N), .level(lines_q.dsr), .rst_level(1'b1),
      .rise_only(1'b0), .clr(mls_rd & PRDATA[1]), .flag(chg[1]));
   umsab_edge u_cts (.clk(MCLK), .rst_n(RST_N), .level(lines_q.cts), .rst_level(1'b0),
      .rise_only(1'b0), .clr(mls_rd & PRDATA[0]), .flag(chg[0]));

   // Modem interrupt from any pending change flag
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         MS_INT <= 1'b0;
      else
         MS_INT <= MS_INT_EN & (|chg);
   end

   // Scratch byte
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         scr_q <= SCR_RST;
      else if (wr_en & hit_scr)
         scr_q <= PWDATA[7:0];
   end

   // Auto-baud control bits
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rearm_q <= 1'b0;
         mode_q <= 1'b0;
      end
      else if (wr_en & hit_abc)
      begin
         rearm_q <= PWDATA[ABC_RARM_B];
         mode_q <= PWDATA[ABC_MODE_B];
      end
   end

   // Run bit: set by software, cleared by completion or timeout without rearm
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         start_q <= 1'b0;
      else if (AB_EVT.done)
         start_q <= 1'b0;
      else if (wr_en & hit_abc)
         start_q <= PWDATA[ABC_START_B] | start_q;
      else if (AB_EVT.timeout & ~rearm_q)
         start_q <= 1'b0;
   end

   // Timeout rearm: restart strobe at next falling receive edge
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         rxd_q <= 1'b1;
      else
         rxd_q <= RXD;
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         timed_out_q <= 1'b0;
      else if (AB_EVT.timeout & rearm_q & start_q)
         timed_out_q <= 1'b1;
      else if (rxd_q & ~RXD | ~start_q)
         timed_out_q <= 1'b0;
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         AB_RESTART <= 1'b0;
      else
         AB_RESTART <= timed_out_q & rearm_q & start_q & rxd_q & ~RXD;
   end

   // Sticky auto-baud flags, event wins over clear
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         AB_DONE_FLAG <= 1'b0;
      else if (AB_EVT.done)
         AB_DONE_FLAG <= 1'b1;
      else if (wr_en & hit_abc & PWDATA[ABC_EOC_B])
         AB_DONE_FLAG <= 1'b0;
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         AB_TIMEOUT_FLAG <= 1'b0;
      else if (AB_EVT.timeout)
         AB_TIMEOUT_FLAG <= 1'b1;
      else if (wr_en & hit_abc & PWDATA[ABC_TOC_B])
         AB_TIMEOUT_FLAG <= 1'b0;
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         AB_START <= 1'b0;
         AB_MODE <= 1'b0;
      end
      else
      begin
         AB_START <= start_q;
         AB_MODE <= mode_q;
      end
   end

   // Read mux; status has no write path
   always_comb
   begin
      rdata_d = ZERO_WORD;
      if (hit_mls)
      begin
         rdata_d[MLS_DCD_B] = lines_q.dcd;
         rdata_d[MLS_RI_B] = lines_q.ri;
         rdata_d[MLS_DSR_B] = lines_q.dsr;
         rdata_d[MLS_CTS_B] = lines_q.cts;
         rdata_d[3:0] = chg;
      end
      else if (hit_scr)
         rdata_d[7:0] = scr_q;
      else if (hit_abc)
      begin
         rdata_d[ABC_RARM_B] = rearm_q;
         rdata_d[ABC_MODE_B] = mode_q;
         rdata_d[ABC_START_B] = start_q; // clear bits read 0
      end
   end

   // APB answer: data registered in setup, ready in access
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         PRDATA <= ZERO_WORD;
      else if (setup_ph & ~PWRITE)
         PRDATA <= rdata_d;
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY <= setup_ph;
         PSLVERR <= setup_ph & ~(hit_mls | hit_scr | hit_abc);
      end
   end

   // Assertions
   a_dcd_change_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
      $changed(lines_q.dcd) |=> chg[3]) else $error("dcd change missed");
   a_ri_rise_only: assert property (@(posedge MCLK) disable iff (!RST_N)
      ($fell(lines_q.ri) && !chg[2]) |=> chg[2]) else $error("ri flag missed");
   a_ri_no_fall: assert property (@(posedge MCLK) disable iff (!RST_N)
      ($rose(lines_q.ri) && !chg[2]) |=> !chg[2]) else $error("ri flag wrong edge");
   a_read_clears: assert property (@(posedge MCLK) disable iff (!RST_N)
      (mls_rd && PRDATA[1:0] == chg[1:0] && lines_d == lines_q && $stable(lines_q))
      |=> chg[1:0] == 2'b00)
      else $error("status read did not clear");
   a_cts_flag_set: assert property (@(posedge MCLK) disable iff (!RST_N)
      $changed(lines_q.cts) |=> chg[0]) else $error("cts change missed");
   a_status_roi: assert property (@(posedge MCLK) disable iff (!RST_N)
      (PREADY && !PWRITE && PADDR == MLS_ADDR) |-> PRDATA[31:8] == 24'h000000)
      else $error("status upper bits nonzero");
   a_scratch_write: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_en && hit_scr) |=> scr_q == $past(PWDATA[7:0])) else $error("scratch lost");
   a_done_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_en && hit_abc && PWDATA[ABC_EOC_B] && !AB_EVT.done) |=> !AB_DONE_FLAG)
      else $error("done flag not cleared");
   a_timeout_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_en && hit_abc && PWDATA[ABC_TOC_B] && !AB_EVT.timeout) |=> !AB_TIMEOUT_FLAG)
      else $error("timeout flag not cleared");
   a_start_ends: assert property (@(posedge MCLK) disable iff (!RST_N)
      AB_EVT.done |=> !start_q ##1 !AB_START) else $error("run bit stuck");
   a_flag_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
      AB_EVT.done |=> AB_DONE_FLAG) else $error("done flag not set");
   a_int_on_change: assert property (@(posedge MCLK) disable iff (!RST_N)
      (MS_INT_EN && chg[3]) |=> MS_INT) else $error("no modem interrupt");

   c_status_read: cover property (@(posedge MCLK) disable iff (!RST_N) mls_rd && chg != 4'h0);
   c_loopback: cover property (@(posedge MCLK) disable iff (!RST_N) LOOPBACK && $changed(lines_q));
   c_restart: cover property (@(posedge MCLK) disable iff (!RST_N) AB_RESTART);
   c_done: cover property (@(posedge MCLK) disable iff (!RST_N) AB_EVT.done && start_q);
endmodule
`default_nettype wire

//--- tb/test_uart_modem_status_autobaud_regs.sv
// Self-checking bench for the modem status, scratch and auto-baud slice
`timescale 1ns/100ps
`default_nettype none
module test_uart_modem_status_autobaud_regs;
   import umsab_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = ZERO_WORD;
   logic loopback = 1'b0;
   logic [3:0] modem_ctrl = 4'h0;
   logic ms_int_en = 1'b0;
   umsab_ab_evt_t ab_evt = '0;
   logic [31:0] prdata, rd, w;
   logic pready, pslverr, dcd_n, ri_n, dsr_n, cts_n, rxd, er;
   logic ms_int, ab_start, ab_mode, ab_restart, ab_done_flag, ab_timeout_flag;
   logic [3:0] pins = 4'hF;
   logic [3:0] flg = 4'h0;
   logic [3:0] v;
   int err_total = 0;
   int checks = 0;
   int n;
   always #5 mclk = ~mclk;
   umsab_regs umsab_regs_inst (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .DCD_N(dcd_n), .RI_N(ri_n), .DSR_N(dsr_n), .CTS_N(cts_n),
      .RXD(rxd), .LOOPBACK(loopback), .MODEM_CTRL(modem_ctrl), .MS_INT_EN(ms_int_en),
      .AB_EVT(ab_evt), .MS_INT(ms_int), .AB_START(ab_start), .AB_MODE(ab_mode),
      .AB_RESTART(ab_restart), .AB_DONE_FLAG(ab_done_flag),
      .AB_TIMEOUT_FLAG(ab_timeout_flag));
   umsab_modem umsab_modem_inst (.clk(mclk), .dcd_n(dcd_n), .ri_n(ri_n), .dsr_n(dsr_n),
      .cts_n(cts_n), .rxd(rxd));
   task automatic report_and_stop();
      $display("counts: %0d checks, %0d mismatches", checks, err_total);
      if (err_total == 0 && checks > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One transfer; answer taken at the rising edge that sees pready high
   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         err_total++;
         report_and_stop();
      end
      else
      begin
         r = prdata;
         e = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, ZERO_WORD, rd, er);
      chk_word(rd & m, e);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic pulse(input logic d, input logic t);
      @(posedge mclk);
      ab_evt <= umsab_ab_evt_t'({d, t});
      @(posedge mclk);
      ab_evt <= '0;
   endtask
   task automatic tdone(input string s);
      $display("test %0s finished", s);
   endtask
   function automatic logic [31:0] ms_exp();
      return {24'h000000, ~pins, flg};
   endfunction
   initial
   begin
      void'($urandom(32'hD9B0));
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rdc(ABC_ADDR, ZERO_WORD, '1);
      rdc(SCR_ADDR, ZERO_WORD, '1);
      cyc(1);
      chk_bit(ab_start | ab_mode | ab_done_flag | ab_timeout_flag, 1'b0);
      cyc(6);
      apb(1'b0, MLS_ADDR, ZERO_WORD, rd, er);
      cyc(4);
      rdc(MLS_ADDR, ms_exp(), '1);
      tdone("reset");
      for (int i = 0; i < 12; i++)
      begin
         v = 4'($urandom());
         v[2] = i[0];
         @(posedge mclk);
         ms_int_en <= i[1];
         umsab_modem_inst.set_lines(v, $urandom_range(3));
         flg |= {pins[3] ^ v[3], ~pins[2] & v[2], pins[1] ^ v[1], pins[0] ^ v[0]};
         pins = v;
         cyc(5);
         chk_bit(ms_int, ms_int_en & (|flg));
         rdc(MLS_ADDR, ms_exp(), '1);
         flg = 4'h0;
         cyc(4);
         chk_bit(ms_int, 1'b0);
      end
      tdone("modem lines");
      wr(MLS_ADDR, 32'hFFFFFFFF);
      ms_int_en <= 1'b1;
      rdc(MLS_ADDR, ms_exp(), '1);
      for (int i = 0; i < 4; i++)
      begin
         w = $urandom();
         wr(SCR_ADDR, w);
         rdc(SCR_ADDR, w & 32'h000000FF, '1);
      end
      rdc(MLS_ADDR, ms_exp(), '1);
      cyc(1);
      chk_bit(ms_int, 1'b0);
      apb(1'b1, 12'h024, 32'hFFFFFFFF, rd, er);
      chk_bit(er, 1'b1);
      apb(1'b0, 12'h024, ZERO_WORD, rd, er);
      chk_word({rd[30:0], er}, 32'h00000001);
      rdc(SCR_ADDR, w & 32'h000000FF, '1);
      tdone("scratch");
      @(posedge mclk);
      ms_int_en <= 1'b0;
      loopback <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         modem_ctrl <= 4'($urandom());
         cyc(3);
         rdc(MLS_ADDR, {24'h0, modem_ctrl[3:2], modem_ctrl[0], modem_ctrl[1], 4'h0},
            32'h000000F0);
      end
      loopback <= 1'b0;
      cyc(5);
      apb(1'b0, MLS_ADDR, ZERO_WORD, rd, er);
      cyc(4);
      rdc(MLS_ADDR, ms_exp(), '1);
      tdone("loopback");
      wr(ABC_ADDR, 32'h00000003);
      rdc(ABC_ADDR, 32'h00000003, '1);
      cyc(1);
      chk_bit(ab_mode & ab_start, 1'b1);
      pulse(1'b1, 1'b0);
      cyc(2);
      chk_bit(ab_done_flag, 1'b1);
      rdc(ABC_ADDR, 32'h00000002, '1);
      wr(ABC_ADDR, 32'h00000002);
      cyc(2);
      chk_bit(ab_done_flag, 1'b1);
      wr(ABC_ADDR, 32'h00000102);
      cyc(2);
      chk_bit(ab_done_flag, 1'b0);
      rdc(ABC_ADDR, 32'h00000002, '1);
      for (int r = 1; r >= 0; r--)
      begin
         wr(ABC_ADDR, {29'h0, r[0], 2'b01});
         pulse(1'b0, 1'b1);
         cyc(2);
         chk_bit(ab_timeout_flag, 1'b1);
         rdc(ABC_ADDR, {29'h0, r[0], 1'b0, r[0]}, '1);
         umsab_modem_inst.set_rxd(1'b0);
         n = 0;
         repeat (8)
         begin
            @(negedge mclk);
            n += (ab_restart === 1'b1);
         end
         chk_word(n, r);
         umsab_modem_inst.set_rxd(1'b1);
         wr(ABC_ADDR, 32'h00000200);
         cyc(2);
         chk_bit(ab_timeout_flag, 1'b0);
      end
      tdone("auto-baud");
      report_and_stop();
   end
endmodule
`default_nettype wire

//--- tb/umsab_modem.sv
// Behavioural modem driving the handshake pins and the receive line
`timescale 1ns/100ps
`default_nettype none
module umsab_modem
(
   // Clock
   input wire logic clk,
   // Handshake pins, active low, and receive line
   output logic dcd_n,
   output logic ri_n,
   output logic dsr_n,
   output logic cts_n,
   output logic rxd
);
   initial
   begin
      {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
      rxd = 1'b1;
   end
   // New pin levels after a lag, prompt or slow
   task automatic set_lines(input logic [3:0] v, input int lag);
      repeat (lag + 1) @(posedge clk);
      {dcd_n, ri_n, dsr_n, cts_n} <= v;
   endtask
   // Receive line held at mark outside frames
   task automatic set_rxd(input logic v);
      @(posedge clk);
      rxd <= v;
   endtask
endmodule
`default_nettype wire
